// ### shared/ivm_pkg.sv
// constants and types for the interrupt vector mapping block
// assumes a 20-bit byte address map and a 16-bit memory read port
package ivm_pkg;
    localparam int ADDR_W = 20;
    localparam int VEC_BYTES = 4;
    localparam int REL_ENTRIES = 64;
    localparam int REL_TABLE_BYTES = 256;
    localparam int PERIPH_SRC = 28;
    localparam int MATCH_REGS = 4;
    localparam logic [19:0] FIXED_BASE = 20'hFFFDC;
    localparam logic [19:0] FIXED_END = 20'hFFFFF;
    localparam logic [19:0] VEC_UNDEF = 20'hFFFDC;
    localparam logic [19:0] VEC_OVFL = 20'hFFFE0;
    localparam logic [19:0] VEC_BREAK = 20'hFFFE4;
    localparam logic [19:0] VEC_BREAK_HI = 20'hFFFE7;
    localparam logic [19:0] VEC_MATCH = 20'hFFFE8;
    localparam logic [19:0] VEC_STEP = 20'hFFFEC;
    localparam logic [19:0] VEC_SHARED = 20'hFFFF0;
    localparam logic [19:0] VEC_DEBUG = 20'hFFFF4;
    localparam logic [19:0] VEC_NMI = 20'hFFFF8;
    localparam logic [19:0] VEC_RESET = 20'hFFFFC;
    localparam logic [7:0] BREAK_REDIRECT = 8'hFF;
    localparam logic [5:0] SWN_BREAK = 6'h00;
    localparam logic [5:0] SWN_FIRST_HW = 6'h04;
    localparam logic [5:0] SWN_EXT3 = 6'h04;
    localparam logic [5:0] SWN_LAST_HW = 6'h1F;
    localparam logic [19:0] VBASE_RESET = 20'h00000;
    localparam logic [2:0] LEVEL_RESET = 3'h0;
    // extra cycle spent when the table base is odd (one more state, same number of bus accesses)
    localparam int ODD_BASE_EXTRA = 1;

    typedef enum {
        ST_IDLE, ST_FETCH_LO, ST_FETCH_HI, ST_ODD_LO, ST_ODD_HI, ST_CHECK_BRK, ST_BRANCH
    } ivm_state_type;
endpackage

// ### src/ivm_match.sv
// one address-match comparator slot
// assumes pc and match address are stable for the cycle that decode is valid
`timescale 1ns/1ps
module ivm_match
    import ivm_pkg::*;
(
    input wire logic [19:0] pc,
    input wire logic [19:0] match_addr,
    input wire logic enable,
    output logic hit
);
    assign hit = enable && (pc == match_addr);
endmodule

// ### src/ivm_sync.sv
// three-stage synchroniser for one asynchronous pin, change accepted when stages 2 and 3 agree
// assumes one clock MCLK and synchronous active-high reset
`timescale 1ns/1ps
module ivm_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic din,
    input wire logic init,
    output logic dout
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } ivm_sync_type;
    ivm_sync_type r, next_r;
    always_comb begin
        next_r = r;
        next_r.s1 = din;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        if (r.s2 == r.s3) begin
            next_r.q = r.s3;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            r <= {init, init, init, init};
        end else begin
            r <= next_r;
        end
    end
    assign dout = r.q;
endmodule

// ### src/ivm_top.sv
// interrupt source to vector mapping and vector fetch sequencer
// assumes a CPU core that reports instruction boundaries and traps, and a 16-bit
// memory port that answers a read with mem_ready; peripheral requests are same-clock logic
`timescale 1ns/1ps
module ivm_top
    import ivm_pkg::*;
(
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic INSN_BOUNDARY,
    input wire logic [19:0] NEXT_PC,
    input wire logic TRAP_UNDEF,
    input wire logic TRAP_OVFL,
    input wire logic OVFL_FLAG,
    input wire logic TRAP_BREAK,
    input wire logic SW_INT,
    input wire logic [5:0] SW_INT_NUM,
    input wire logic SINGLE_STEP,
    input wire logic DEBUG_BREAK_IRQ,
    input wire logic NMI_PIN_N,
    input wire logic WATCHDOG_IRQ,
    input wire logic OSC_STOP_IRQ,
    input wire logic LOW_VOLT_IRQ,
    input wire logic [19:0] VECTOR_TABLE_BASE,
    input wire logic [79:0] MATCH_ADDRESS_REGS,
    input wire logic [1:0] MATCH_ENABLE_REG_LOW,
    input wire logic [1:0] MATCH_ENABLE_REG_HIGH,
    input wire logic GLOBAL_ENABLE,
    input wire logic [2:0] PROCESSOR_LEVEL,
    input wire logic [PERIPH_SRC-1:0] PERIPH_REQ,
    input wire logic [3*PERIPH_SRC-1:0] PERIPH_LEVEL,
    input wire logic [1:0] COLLISION_REQ,
    input wire logic [2:0] I2C_MODE,
    input wire logic [5:0] I2C_ACK_REQ,
    input wire logic SEL8_EXT_PIN,
    input wire logic SEL9_EXT_PIN,
    input wire logic EXT_PIN_IRQ_5,
    input wire logic EXT_PIN_IRQ_4,
    input wire logic [15:0] MEM_RDATA,
    input wire logic MEM_READY,
    output logic MEM_REQ,
    output logic [19:0] MEM_ADDR,
    output logic BUSY,
    output logic [PERIPH_SRC-1:0] PERIPH_ACK,
    output logic [2:0] NEW_LEVEL,
    output logic SET_LEVEL,
    output logic BRANCH,
    output logic [19:0] BRANCH_ADDR,
    output logic MATCH_IRQ
);
    typedef struct packed {
        ivm_state_type st;
        logic [19:0] addr;
        logic [19:0] vec;
        logic [7:0] odd_byte;
        logic is_break;
        logic nmi_prev;
        logic nmi_pend;
        logic req;
        logic [PERIPH_SRC-1:0] ack;
        logic [2:0] lvl;
        logic set_lvl;
        logic branch;
        logic match;
    } ivm_top_type;
    ivm_top_type r, next_r;

    logic nmi_pin;
    logic [MATCH_REGS-1:0] hit;
    logic [MATCH_REGS-1:0] men;
    logic [PERIPH_SRC-1:0] src;
    logic [PERIPH_SRC-1:0] elig;
    logic [4:0] win_idx;
    logic [2:0] win_lvl;
    logic win_any;

    // asynchronous pin: three stages, then the edge detector sees settled levels
    ivm_sync u_nmi (
        .clk(MCLK),
        .rst(SYS_RST),
        .din(NMI_PIN_N),
        .init(1'b1),
        .dout(nmi_pin)
    );

    assign men = {MATCH_ENABLE_REG_HIGH, MATCH_ENABLE_REG_LOW};
    // a disabled slot never hits, whatever its address holds
    genvar g;
    generate
        for (g = 0; g < MATCH_REGS; g++) begin : g_match
            ivm_match u_m (
                .pc(NEXT_PC),
                .match_addr(MATCH_ADDRESS_REGS[20*g +: 20]),
                .enable(men[g]),
                .hit(hit[g])
            );
        end
    endgenerate

    // index i of src stands for software number i+4; collision slots merged here, I2C and pin slots selected
    always_comb begin
        src = PERIPH_REQ;
        src[2] = PERIPH_REQ[2] | COLLISION_REQ[1];
        src[3] = PERIPH_REQ[3] | COLLISION_REQ[0];
        for (int k = 0; k < 6; k++) begin
            if (I2C_MODE[k/2]) begin
                src[11+k] = I2C_ACK_REQ[k];
            end
        end
        // the deselected requester is ignored, not merged, so it cannot steal the slot
        if (SEL8_EXT_PIN) begin
            src[4] = EXT_PIN_IRQ_5;
        end else begin
            src[4] = PERIPH_REQ[4];
        end
        if (SEL9_EXT_PIN) begin
            src[5] = EXT_PIN_IRQ_4;
        end else begin
            src[5] = PERIPH_REQ[5];
        end
    end

    // highest level wins, ties to the lower number
    always_comb begin
        win_idx = 5'h00;
        win_lvl = 3'h0;
        win_any = 1'b0;
        for (int k = 0; k < PERIPH_SRC; k++) begin
            elig[k] = src[k] && (PERIPH_LEVEL[3*k +: 3] > PROCESSOR_LEVEL);
            if (elig[k] && (!win_any || PERIPH_LEVEL[3*k +: 3] > win_lvl)) begin
                win_any = 1'b1;
                win_idx = 5'(k);
                win_lvl = PERIPH_LEVEL[3*k +: 3];
            end
        end
    end

    always_comb begin
        next_r = r;
        next_r.ack = '0;
        next_r.set_lvl = 1'b0;
        next_r.branch = 1'b0;
        next_r.match = 1'b0;
        next_r.nmi_prev = nmi_pin;
        case (r.st)
            ST_IDLE: begin
                // special causes in fixed order; peripherals only when none is present
                if (INSN_BOUNDARY) begin
                    next_r.st = ST_FETCH_LO;
                    next_r.req = 1'b1;
                    next_r.is_break = 1'b0;
                    if (DEBUG_BREAK_IRQ) begin
                        next_r.addr = VEC_DEBUG;
                    end else if (r.nmi_pend) begin
                        next_r.addr = VEC_NMI;
                        next_r.nmi_pend = 1'b0;
                    end else if (TRAP_UNDEF) begin
                        next_r.addr = VEC_UNDEF;
                    end else if (TRAP_OVFL && OVFL_FLAG) begin
                        next_r.addr = VEC_OVFL;
                    end else if (TRAP_BREAK) begin
                        next_r.addr = VEC_BREAK;
                        next_r.is_break = 1'b1;
                    end else if (SW_INT) begin
                        next_r.addr = 20'(VECTOR_TABLE_BASE + {12'h000, SW_INT_NUM, 2'b00});
                    end else if (|hit) begin
                        next_r.addr = VEC_MATCH;
                        next_r.match = 1'b1;
                    end else if (SINGLE_STEP) begin
                        next_r.addr = VEC_STEP;
                    end else if (WATCHDOG_IRQ || OSC_STOP_IRQ || LOW_VOLT_IRQ) begin
                        next_r.addr = VEC_SHARED;
                    end else if (GLOBAL_ENABLE && win_any) begin
                        next_r.addr = 20'(VECTOR_TABLE_BASE
                            + {12'h000, 6'(win_idx) + SWN_FIRST_HW, 2'b00});
                        // only the winner is acknowledged; the rest keep asking
                        next_r.ack[win_idx] = 1'b1;
                        next_r.lvl = win_lvl;
                        next_r.set_lvl = 1'b1;
                    end else begin
                        next_r.st = ST_IDLE;
                        next_r.req = 1'b0;
                    end
                end
            end

            ST_FETCH_LO: begin
                if (MEM_READY) begin
                    if (r.addr[0]) begin
                        // odd base: split into byte reads, one cycle more in total
                        next_r.odd_byte = MEM_RDATA[7:0];
                        next_r.vec[7:0] = MEM_RDATA[7:0];
                        next_r.addr = 20'(r.addr + 20'h00001);
                        next_r.st = ST_ODD_LO;
                    end else begin
                        next_r.vec[15:0] = MEM_RDATA;
                        next_r.addr = 20'(r.addr + 20'h00002);
                        next_r.st = ST_FETCH_HI;
                    end
                end
            end

            ST_ODD_LO: begin
                if (MEM_READY) begin
                    next_r.vec[15:8] = MEM_RDATA[7:0];
                    next_r.vec[19:16] = MEM_RDATA[11:8];
                    next_r.odd_byte = MEM_RDATA[15:8];
                    next_r.st = ST_ODD_HI;
                    next_r.req = 1'b0;
                end
            end

            ST_ODD_HI: begin
                // odd base pays this state for the split byte access
                next_r.st = ST_CHECK_BRK;
            end

            ST_FETCH_HI: begin
                if (MEM_READY) begin
                    // second word: top address nibble low, break check byte high
                    next_r.vec[19:16] = MEM_RDATA[3:0];
                    next_r.odd_byte = MEM_RDATA[15:8];
                    next_r.req = 1'b0;
                    next_r.st = ST_CHECK_BRK;
                end
            end

            ST_CHECK_BRK: begin
                // odd_byte holds the top byte of the vector just read from an even base; from an odd base it holds the byte that carries vec[19:16]
                if (r.is_break && r.odd_byte == BREAK_REDIRECT) begin
                    next_r.is_break = 1'b0;
                    next_r.addr = 20'(VECTOR_TABLE_BASE
                        + {12'h000, SWN_BREAK, 2'b00});
                    next_r.req = 1'b1;
                    next_r.st = ST_FETCH_LO;
                end else begin
                    next_r.st = ST_BRANCH;
                end
            end

            ST_BRANCH: begin
                next_r.branch = 1'b1;
                next_r.st = ST_IDLE;
            end

            default: begin
                next_r.st = ST_IDLE;
            end
        endcase
        // edge capture after the case: a new edge in the taking cycle wins over the clear
        if (r.nmi_prev && !nmi_pin) begin
            next_r.nmi_pend = 1'b1;
        end
    end

    // pin history starts at the released level, so reset shows no false edge
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            r <= '{st: ST_IDLE, addr: VBASE_RESET, vec: VBASE_RESET, odd_byte: 8'h00,
                   is_break: 1'b0, nmi_prev: 1'b1, nmi_pend: 1'b0, req: 1'b0,
                   ack: '0, lvl: LEVEL_RESET, set_lvl: 1'b0, branch: 1'b0,
                   match: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from the state register; only BUSY is decoded
    assign MEM_REQ = r.req;
    assign MEM_ADDR = r.addr;
    assign BUSY = (r.st != ST_IDLE);
    assign PERIPH_ACK = r.ack;
    assign NEW_LEVEL = r.lvl;
    assign SET_LEVEL = r.set_lvl;
    assign BRANCH = r.branch;
    assign BRANCH_ADDR = r.vec;
    assign MATCH_IRQ = r.match;
endmodule

// ### testbench/interrupt_vector_mapping_tb.sv
// self-checking bench for the vector mapping top with a memory model
// assumes the model answers every fetch; expectations come from bench functions
`timescale 1ns/1ps
module interrupt_vector_mapping_tb;
    import ivm_pkg::*;
    logic mclk = 1'b0, sys_rst = 1'b1, bnd = 1'b0, t_und = 1'b0, t_ovf = 1'b0, ovf_f = 1'b0;
    logic t_brk = 1'b0, swi = 1'b0, step = 1'b0, dbg = 1'b0, nmi_n = 1'b1, wdt = 1'b0;
    logic osc = 1'b0, lvd = 1'b0, ge = 1'b1, sel8 = 1'b0, sel9 = 1'b0, slow = 1'b0, brk_ff = 1'b0;
    logic [19:0] npc = 20'h0, vbase = 20'h0;
    logic [79:0] mregs = '0;
    logic [1:0] men_lo = 2'h0, men_hi = 2'h0, coll = 2'h0;
    logic [2:0] plvl = 3'h0, i2c_m = 3'h0;
    logic [5:0] swn = 6'h0, i2c_a = 6'h0;
    logic [27:0] preq = '0, pack;
    logic [83:0] plev = '0;
    logic [15:0] rdata;
    logic rdy, mreq, busy, setl, br, mirq, mi;
    logic xp5 = 1'b0, xp4 = 1'b0;
    logic [19:0] maddr, br_a;
    logic [2:0] nlvl, lv;
    int errors = 0, total_checks = 0;
    always #12.5 mclk = ~mclk;
    ivm_top DUT (.MCLK(mclk), .SYS_RST(sys_rst), .INSN_BOUNDARY(bnd), .NEXT_PC(npc),
        .TRAP_UNDEF(t_und), .TRAP_OVFL(t_ovf), .OVFL_FLAG(ovf_f), .TRAP_BREAK(t_brk),
        .SW_INT(swi), .SW_INT_NUM(swn), .SINGLE_STEP(step), .DEBUG_BREAK_IRQ(dbg),
        .NMI_PIN_N(nmi_n), .WATCHDOG_IRQ(wdt), .OSC_STOP_IRQ(osc), .LOW_VOLT_IRQ(lvd),
        .VECTOR_TABLE_BASE(vbase), .MATCH_ADDRESS_REGS(mregs), .MATCH_ENABLE_REG_LOW(men_lo),
        .MATCH_ENABLE_REG_HIGH(men_hi), .GLOBAL_ENABLE(ge), .PROCESSOR_LEVEL(plvl),
        .PERIPH_REQ(preq), .PERIPH_LEVEL(plev), .COLLISION_REQ(coll), .I2C_MODE(i2c_m),
        .I2C_ACK_REQ(i2c_a), .SEL8_EXT_PIN(sel8), .SEL9_EXT_PIN(sel9), .EXT_PIN_IRQ_5(xp5),
        .EXT_PIN_IRQ_4(xp4), .MEM_RDATA(rdata),
        .MEM_READY(rdy), .MEM_REQ(mreq), .MEM_ADDR(maddr), .BUSY(busy), .PERIPH_ACK(pack),
        .NEW_LEVEL(nlvl), .SET_LEVEL(setl), .BRANCH(br), .BRANCH_ADDR(br_a), .MATCH_IRQ(mirq));
    ivm_mem_model MEM (.clk(mclk), .req(mreq), .addr(maddr), .slow(slow), .brk_ff(brk_ff),
        .ready(rdy), .rdata(rdata));
    function automatic logic [15:0] wd(input logic [19:0] a);
        return {a[7:0], a[15:8]} ^ 16'h1234;
    endfunction
    function automatic logic [19:0] vec(input logic [19:0] a);
        logic [15:0] h;
        h = wd(a + 20'h2);
        return {h[3:0], wd(a)};
    endfunction
    task automatic ck(input bit ok, input string m);
        total_checks++;
        if (!ok) begin
            errors++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // one boundary, then watch the fetch; sources drop once the boundary is sampled
    task automatic go(input logic [19:0] va, input bit take, input bit chk, output int cyc,
        output logic [27:0] ak);
        bit seen;
        logic [19:0] got;
        seen = 0;
        got = 20'h0;
        ak = '0;
        cyc = 0;
        mi = 1'b0;
        lv = 3'h0;
        @(posedge mclk) bnd <= 1'b1;
        @(posedge mclk) bnd <= 1'b0;
        {t_und, t_ovf, ovf_f, t_brk, swi, step, dbg, wdt, osc, lvd} <= '0;
        {preq, coll, i2c_a, men_lo, men_hi, xp5, xp4} <= '0;
        for (int n = 0; n < 60 && cyc == 0; n++) begin
            @(negedge mclk);
            if (mreq === 1'b1 && maddr === va) seen = 1;
            ak |= pack;
            mi = mi | mirq;
            if (setl === 1'b1) lv = nlvl;
            if (br === 1'b1) begin
                cyc = n + 1;
                got = br_a;
            end
        end
        ck(seen == take && (cyc != 0) == take, "vector fetch");
        if (take && chk) ck(got === vec(va), "branch address");
        @(posedge mclk);
    endtask
    initial begin
        #(25ns * 10000);
        errors++;
        test_done();
    end
    initial begin
        int c0, c1;
        logic [27:0] ak;
        logic [19:0] b;
        void'($urandom(32'he5f3ddf1));
        b = 20'($urandom) & 20'h7FFFC;
        {vbase, npc, sel8, sel9} <= {b, 20'($urandom), 2'($urandom)};
        mregs <= 80'({$urandom, $urandom, $urandom});
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge mclk);
        dbg <= 1'b1; go(VEC_DEBUG, 1, 1, c0, ak);
        t_und <= 1'b1; go(VEC_UNDEF, 1, 1, c0, ak);
        {t_ovf, ovf_f} <= 2'h3; go(VEC_OVFL, 1, 1, c0, ak);
        t_ovf <= 1'b1; go(VEC_OVFL, 0, 0, c0, ak);
        t_brk <= 1'b1; go(VEC_BREAK, 1, 1, c0, ak);
        {t_brk, brk_ff} <= 2'h3; go(b, 1, 1, c0, ak);
        {brk_ff, step} <= 2'h1; go(VEC_STEP, 1, 1, c0, ak);
        for (int k = 0; k < 3; k++) begin
            {ge, wdt, osc, lvd} <= {1'b0, 3'h4 >> k}; go(VEC_SHARED, 1, 1, c0, ak);
        end
        nmi_n <= 1'b0;
        repeat (6) @(posedge mclk);
        nmi_n <= 1'b1; go(VEC_NMI, 1, 1, c0, ak);
        ge <= 1'b1;
        $display("test fixed vectors done");
        for (int k = 0; k < 4; k++) begin
            npc <= mregs[20*k +: 20];
            {men_hi, men_lo} <= 4'h1 << k; go(VEC_MATCH, 1, 1, c0, ak);
            ck(mi === 1'b1, "match pulse");
            {men_hi, men_lo} <= ~(4'h1 << k); go(VEC_MATCH, 0, 0, c0, ak);
            ck(mi === 1'b0, "match pulse");
        end
        $display("test address match done");
        for (int k = 0; k < 64; k++) begin
            {swi, swn, slow} <= {1'b1, 6'(k), 1'($urandom)}; go(b + 20'(4 * k), 1, 1, c0, ak);
        end
        slow <= 1'b0;
        $display("test software numbers done");
        for (int k = 0; k < 28; k++) begin
            plev <= 84'({$urandom, $urandom, $urandom}) | (84'h7 << 3 * k);
            {plvl, preq} <= {3'($urandom_range(0, 6)), 28'h1 << k};
            {xp5, xp4} <= {k == 4, k == 5};
            go(b + 20'(4 * k + 16), 1, 1, c0, ak);
            ck(ak === 28'h1 << k, "peripheral ack");
            ck(lv === 3'h7, "new level");
        end
        {ge, plev, plvl, preq} <= {1'b0, {84{1'b1}}, 3'h0, 28'h1 << 9};
        go(b + 20'd52, 0, 0, c0, ak);
        {ge, plvl, preq} <= {1'b1, 3'h7, 28'h1 << 9}; go(b + 20'd52, 0, 0, c0, ak);
        {plev, plvl} <= {{84{1'b1}}, 3'h0};
        coll <= 2'h2; go(b + 20'd24, 1, 1, c0, ak);
        coll <= 2'h1; go(b + 20'd28, 1, 1, c0, ak);
        {sel8, xp5} <= 2'h3; go(b + 20'd32, 1, 1, c0, ak);
        {sel8, xp5} <= 2'h1; go(b + 20'd32, 0, 0, c0, ak);
        {sel9, preq} <= {1'b1, 28'h1 << 5}; go(b + 20'd36, 0, 0, c0, ak);
        {sel9, xp4} <= 2'h3; go(b + 20'd36, 1, 1, c0, ak);
        for (int k = 0; k < 6; k++) begin
            {i2c_m, i2c_a} <= {3'h1 << k / 2, 6'h1 << k}; go(b + 20'(60 + 4 * k), 1, 1, c0, ak);
        end
        {i2c_m, preq} <= {3'h1, 28'h1 << 11}; go(b + 20'd60, 0, 0, c0, ak);
        i2c_m <= 3'h0;
        $display("test peripheral sources done");
        {swi, swn} <= {1'b1, 6'd9}; go(b + 20'd36, 1, 1, c0, ak);
        vbase <= b | 20'h1;
        {swi, swn} <= {1'b1, 6'd9}; go(b + 20'd37, 1, 0, c1, ak);
        ck(c1 == c0 + ODD_BASE_EXTRA, "odd base cycle count");
        $display("test base parity done");
        test_done();
    end
endmodule

// ### testbench/ivm_chk.sv
// port-level assertions for the vector mapping top
// assumes one clock and synchronous active-high reset
`timescale 1ns/1ps
module ivm_chk
    import ivm_pkg::*;
(
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic INSN_BOUNDARY,
    input wire logic [19:0] NEXT_PC,
    input wire logic DEBUG_BREAK_IRQ,
    input wire logic [79:0] MATCH_ADDRESS_REGS,
    input wire logic [1:0] MATCH_ENABLE_REG_LOW,
    input wire logic [1:0] MATCH_ENABLE_REG_HIGH,
    input wire logic GLOBAL_ENABLE,
    input wire logic MEM_READY,
    input wire logic MEM_REQ,
    input wire logic [19:0] MEM_ADDR,
    input wire logic BUSY,
    input wire logic [PERIPH_SRC-1:0] PERIPH_ACK,
    input wire logic BRANCH
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    logic [3:0] en;
    logic hit;
    assign en = {MATCH_ENABLE_REG_HIGH, MATCH_ENABLE_REG_LOW};
    always_comb begin
        hit = 1'b0;
        for (int s = 0; s < 4; s++) begin
            if (en[s] && MATCH_ADDRESS_REGS[20*s +: 20] == NEXT_PC) hit = 1'b1;
        end
    end
    mem_hold_a: assert property (MEM_REQ && !MEM_READY |=> MEM_REQ && $stable(MEM_ADDR))
        else $error("fetch request dropped or moved before ready");
    debug_vec_a: assert property (INSN_BOUNDARY && !BUSY && DEBUG_BREAK_IRQ
        |-> ##[1:2] (MEM_REQ && MEM_ADDR == VEC_DEBUG)) else $error("debug vector not fetched");
    match_cause_a: assert property ($rose(MEM_REQ) && MEM_ADDR == VEC_MATCH
        |-> $past(hit) || $past(hit, 2)) else $error("match vector without enabled hit");
    ack_enable_a: assert property (|PERIPH_ACK
        |-> $past(GLOBAL_ENABLE) || $past(GLOBAL_ENABLE, 2)) else $error("ack while disabled");
    ack_single_a: assert property ($onehot0(PERIPH_ACK))
        else $error("more than one peripheral acknowledged");
    branch_pulse_a: assert property (BRANCH |=> !BRANCH)
        else $error("branch longer than one cycle");
    idle_quiet_a: assert property (!BUSY |-> !MEM_REQ)
        else $error("fetch while idle");
    fetch_done_a: assert property ($rose(MEM_REQ) |-> ##[1:40] BRANCH)
        else $error("no branch after vector fetch");
    reset_clear_a: assert property (disable iff (1'b0) SYS_RST |=> !MEM_REQ && !BRANCH)
        else $error("outputs active after reset");
    cover property (BRANCH);
    cover property ($rose(MEM_REQ) && MEM_ADDR == VEC_MATCH);
    cover property (|PERIPH_ACK);
endmodule
bind ivm_top ivm_chk u_chk (.MCLK(MCLK), .SYS_RST(SYS_RST), .INSN_BOUNDARY(INSN_BOUNDARY),
    .NEXT_PC(NEXT_PC), .DEBUG_BREAK_IRQ(DEBUG_BREAK_IRQ), .MATCH_ADDRESS_REGS(MATCH_ADDRESS_REGS),
    .MATCH_ENABLE_REG_LOW(MATCH_ENABLE_REG_LOW), .MATCH_ENABLE_REG_HIGH(MATCH_ENABLE_REG_HIGH),
    .GLOBAL_ENABLE(GLOBAL_ENABLE), .MEM_READY(MEM_READY), .MEM_REQ(MEM_REQ),
    .MEM_ADDR(MEM_ADDR), .BUSY(BUSY), .PERIPH_ACK(PERIPH_ACK), .BRANCH(BRANCH));

// ### testbench/ivm_mem_model.sv
// behavioural vector memory on the far side of the fetch port
// assumes requests hold until ready; answers at once or after two waits
`timescale 1ns/1ps
module ivm_mem_model (
    input wire logic clk,
    input wire logic req,
    input wire logic [19:0] addr,
    input wire logic slow,
    input wire logic brk_ff,
    output logic ready,
    output logic [15:0] rdata
);
    logic [1:0] cnt;
    logic [15:0] w;
    always_ff @(posedge clk) begin
        cnt <= (!req || ready) ? 2'h0 : cnt + 2'h1;
    end
    always_comb begin
        w = {addr[7:0], addr[15:8]} ^ 16'h1234;
        if (brk_ff && addr == 20'hFFFE6) w[15:8] = 8'hFF;
        ready = req && (!slow || cnt == 2'h2);
        // no stale data between answers: the bus shows the inverse
        rdata = ready ? w : ~w;
    end
endmodule
